/* File: common/color_regs_pkg.sv */
// Purpose: Shared constants and types for the colour result and image update registers
// Assumes: Byte-wide register port, byte addresses as printed
// Notes: Results are stored most significant byte first
package color_regs_pkg;
    // Result window and individual result registers
    localparam logic [7:0] ADDR_RESULT_FIRST = 8'h28;
    localparam logic [7:0] ADDR_RESULT_LAST = 8'h3f;
    localparam logic [7:0] ADDR_U_PRIME = 8'h28;
    localparam logic [7:0] ADDR_V_PRIME = 8'h2c;
    localparam logic [7:0] ADDR_U = 8'h30;
    localparam logic [7:0] ADDR_V = 8'h34;
    localparam logic [7:0] ADDR_LOCUS_DIST = 8'h38;
    localparam logic [7:0] ADDR_LUX_UPPER = 8'h3c;
    localparam logic [7:0] ADDR_LUX_LOWER = 8'h3d;
    localparam logic [7:0] ADDR_CCT_UPPER = 8'h3e;
    localparam logic [7:0] ADDR_CCT_LOWER = 8'h3f;
    // Image update registers
    localparam logic [7:0] ADDR_UPDATE_CONTROL = 8'h48;
    localparam logic [7:0] ADDR_COUNT_UPPER = 8'h49;
    localparam logic [7:0] ADDR_COUNT_LOWER = 8'h4a;
    localparam logic [7:0] ADDR_PAYLOAD = 8'h4b;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h4c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h4d;

    localparam int RESULT_BYTES = 24;
    localparam int RESULT_INDEX_W = 5;
    localparam int RESULT_BITS = 192;

    // Control register bit positions
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_STOP_BIT = 6;
    localparam int CTRL_COMPLETE_BIT = 5;
    localparam int CTRL_LOCK_BIT = 4;
    localparam int CTRL_SWITCH_BIT = 3;
    localparam int CTRL_FIRST_SLOT_BIT = 2;
    localparam int CTRL_FAULT_BIT = 1;
    localparam int CTRL_CHECK_OK_BIT = 0;

    // Interrupt status and mask layout
    localparam int IRQ_W = 3;
    localparam int IRQ_COMPLETE_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;
    localparam int IRQ_RESULT_BIT = 2;

    // Image geometry: 56 kilobytes into one of two flash slots
    localparam logic [15:0] IMAGE_BYTES = 16'he000;
    localparam logic [17:0] SLOT_FIRST_BASE = 18'h12000;
    localparam logic [17:0] SLOT_SECOND_BASE = 18'h22000;

    // Reset values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] PAYLOAD_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
    localparam logic FIRST_SLOT_RESET = 1'b1;
    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef enum {
        UPD_IDLE,
        UPD_RECEIVE,
        UPD_COMPLETE
    } update_state_t;
endpackage

/* File: common/result_store_if.sv */
// Purpose: Link between the register core and the result byte store
// Assumes: One clock domain
// Notes: The store also registers the non-result read byte so read data leave a flop
`timescale 1ns/100ps
`default_nettype none
interface result_store_if;
    logic load;
    logic [191:0] load_data;
    logic rd_en;
    logic rd_from_store;
    logic [4:0] rd_index;
    logic [7:0] rd_other;
    logic [7:0] rd_data;
    modport core (
        output load, load_data, rd_en, rd_from_store, rd_index, rd_other,
        input rd_data
    );
    modport store (
        input load, load_data, rd_en, rd_from_store, rd_index, rd_other,
        output rd_data
    );
endinterface
`default_nettype wire

/* File: core/result_store.sv */
// Purpose: Byte store for the floating-point and integer results, plus read data register
// Assumes: Load vector is packed most significant byte first
// Notes: Read data stand one cycle after the read strobe and read zero otherwise
`timescale 1ns/100ps
`default_nettype none
module result_store
    import color_regs_pkg::*;
(
    input wire logic i_clk,          // System clock
    input wire logic i_resetn,       // Asynchronous reset, active low
    input wire logic i_clk_en,       // Freezes all state while low
    result_store_if.store bus        // Load and read port
);
    logic [7:0] mem [RESULT_BYTES];
    logic [7:0] next_mem [RESULT_BYTES];
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;

    always_comb begin
        next_mem = mem;
        if (bus.load) begin
            for (int i = 0; i < RESULT_BYTES; i++) begin
                next_mem[i] = bus.load_data[RESULT_BITS-1-8*i -: 8];
            end
        end
        next_rd_data = READ_ZERO;
        if (bus.rd_en) begin
            next_rd_data = bus.rd_from_store ? mem[bus.rd_index] : bus.rd_other;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < RESULT_BYTES; i++) begin
                mem[i] <= READ_ZERO;
            end
            rd_data <= READ_ZERO;
        end else if (i_clk_en) begin
            mem <= next_mem;
            rd_data <= next_rd_data;
        end
    end

    assign bus.rd_data = rd_data;
endmodule
`default_nettype wire

/* File: core/color_result_and_image_update_regs.sv */
// Purpose: Result registers and image update control reached over a byte register port
// Assumes: Bus strobes are one cycle, synchronous to i_clk, never both at once
// Notes: Image bytes leave as a one-cycle flash write request with the flash byte address
//
// Behaviour
// - Four chromaticity results readable as 32-bit floats, four bytes each, read-only.
// - Locus distance readable as a read-only 32-bit float over four bytes.
// - Illuminance is a read-only 16-bit integer, upper byte at lower address.
// - Colour temperature is a read-only 16-bit integer, upper byte first.
// - Two image slots in flash starting at two fixed byte addresses.
// - A full image is exactly 56 kilobytes; host sends exactly that.
// - Writing one to control bit 7 enters update mode; bit reads back.
// - Writing one to control bit 6 returns the update machine to idle.
// - Control bit 5 reads one once the whole image has arrived.
// - Control bit 4 locks the current image for the next start-up.
// - Writing one to control bit 3 swaps the selected image slot, except while an image is being received.
// - Control bit 2 reads one while the first slot is active.
// - Control bit 1 is set when a fault occurs during an update.
// - Control bit 0 reports the other slot passed its checksum.
// - Read-only 16-bit received byte count, upper byte first, resets to zero.
// - Each payload write while receiving delivers the next image byte; payload resets to zero.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module color_result_and_image_update_regs
    import color_regs_pkg::*;
(
    input wire logic i_clk,                // System clock, 10 MHz
    input wire logic i_resetn,             // Asynchronous reset, active low
    input wire logic i_clk_en,             // Freezes all state while low
    input wire logic [7:0] i_addr,         // Register byte address
    input wire logic [7:0] i_wdata,        // Register write data
    input wire logic i_wr,                 // Write strobe
    input wire logic i_rd,                 // Read strobe
    output logic [7:0] o_rdata,            // Read data, cycle after i_rd
    input wire logic i_result_load,        // Pulse: new results on the inputs below
    input wire logic [31:0] i_u_prime,     // Float result u'
    input wire logic [31:0] i_v_prime,     // Float result v'
    input wire logic [31:0] i_u,           // Float result u
    input wire logic [31:0] i_v,           // Float result v
    input wire logic [31:0] i_locus_dist,  // Float locus distance
    input wire logic [15:0] i_lux,         // Illuminance in lux
    input wire logic [15:0] i_cct,         // Colour temperature in kelvin
    input wire logic i_flash_fault,        // Pulse: flash write failed
    input wire logic i_other_check_ok,     // Level: other slot checksum valid
    output logic o_flash_wr,               // Pulse: write one image byte
    output logic [17:0] o_flash_addr,      // Flash byte address of that byte
    output logic [7:0] o_flash_data,       // Image byte
    output logic o_update_mode,            // Level: update mode entered
    output logic o_boot_lock,              // Level: keep current image at start-up
    output logic o_first_slot_active,      // Level: first slot selected
    output logic o_irq                     // Level interrupt, active high
);
    result_store_if store_bus ();

    update_state_t state;
    update_state_t next_state;
    logic update_mode;
    logic next_update_mode;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [7:0] payload;
    logic [7:0] next_payload;
    logic fault;
    logic next_fault;
    logic lock;
    logic next_lock;
    logic first_slot;
    logic next_first_slot;
    logic check_ok;
    logic next_check_ok;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_irq_mask;
    logic irq;
    logic next_irq;
    logic flash_wr;
    logic next_flash_wr;
    logic [17:0] flash_addr;
    logic [17:0] next_flash_addr;
    logic [7:0] flash_data;
    logic [7:0] next_flash_data;
    logic [IRQ_W-1:0] events;
    logic [7:0] control_value;
    logic [7:0] read_other;

    // Address decode that picks the result store or the other registers for the read path
    function automatic logic is_result_addr(input logic [7:0] addr);
        is_result_addr = (addr >= ADDR_RESULT_FIRST) && (addr <= ADDR_RESULT_LAST);
    endfunction

    // Image lands in the slot that is not running
    function automatic logic [17:0] target_base(input logic first_active);
        target_base = first_active ? SLOT_SECOND_BASE : SLOT_FIRST_BASE;
    endfunction

    function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                    input logic [7:0] reg_addr);
        wr_hit = wr && (addr == reg_addr);
    endfunction

    result_store u_store (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .bus(store_bus.store)
    );

    // Results packed most significant byte first so lower addresses hold upper bytes
    assign store_bus.load = i_result_load;
    assign store_bus.load_data = {i_u_prime, i_v_prime, i_u, i_v, i_locus_dist,
                                  i_lux, i_cct};

    always_comb begin
        control_value = READ_ZERO;
        control_value[CTRL_START_BIT] = update_mode;
        control_value[CTRL_COMPLETE_BIT] = (state == UPD_COMPLETE);
        control_value[CTRL_LOCK_BIT] = lock;
        control_value[CTRL_FIRST_SLOT_BIT] = first_slot;
        control_value[CTRL_FAULT_BIT] = fault;
        control_value[CTRL_CHECK_OK_BIT] = check_ok;
    end

    // Read path: result bytes come from the store, the rest are muxed here
    always_comb begin
        read_other = READ_ZERO;
        if (i_addr == ADDR_UPDATE_CONTROL) begin
            read_other = control_value;
        end else if (i_addr == ADDR_COUNT_UPPER) begin
            read_other = count[15:8];
        end else if (i_addr == ADDR_COUNT_LOWER) begin
            read_other = count[7:0];
        end else if (i_addr == ADDR_PAYLOAD) begin
            read_other = payload;
        end else if (i_addr == ADDR_IRQ_STATUS) begin
            read_other = {{(8-IRQ_W){1'b0}}, irq_status};
        end else if (i_addr == ADDR_IRQ_MASK) begin
            read_other = {{(8-IRQ_W){1'b0}}, irq_mask};
        end else begin
            read_other = READ_ZERO;
        end
    end

    assign store_bus.rd_en = i_rd;
    assign store_bus.rd_from_store = is_result_addr(i_addr);
    assign store_bus.rd_index = RESULT_INDEX_W'(i_addr - ADDR_RESULT_FIRST);
    assign store_bus.rd_other = read_other;

    // Update machine, control bits and byte counter
    always_comb begin
        next_state = state;
        next_update_mode = update_mode;
        next_count = count;
        next_payload = payload;
        next_fault = fault;
        next_lock = lock;
        next_first_slot = first_slot;
        next_flash_wr = 1'b0;
        next_flash_addr = flash_addr;
        next_flash_data = flash_data;
        next_check_ok = i_other_check_ok;
        events = IRQ_RESET;
        events[IRQ_RESULT_BIT] = i_result_load;

        if (wr_hit(i_wr, i_addr, ADDR_UPDATE_CONTROL)) begin
            next_lock = i_wdata[CTRL_LOCK_BIT];
            next_update_mode = i_wdata[CTRL_START_BIT];
            if (i_wdata[CTRL_START_BIT] && !update_mode) begin
                next_state = UPD_RECEIVE;
                next_count = COUNT_RESET;
                next_fault = 1'b0;
            end else if (!i_wdata[CTRL_START_BIT]) begin
                next_state = UPD_IDLE;
            end
            // Stop wins over a start in the same write
            if (i_wdata[CTRL_STOP_BIT]) begin
                next_state = UPD_IDLE;
                next_update_mode = 1'b0;
                next_count = COUNT_RESET;
                next_fault = 1'b0;
            end
            // Swapping mid-transfer would split the image over both slots
            if (i_wdata[CTRL_SWITCH_BIT] && state != UPD_RECEIVE) begin
                next_first_slot = !first_slot;
            end
        end

        if (wr_hit(i_wr, i_addr, ADDR_PAYLOAD)) begin
            next_payload = i_wdata;
            if (state == UPD_RECEIVE) begin
                next_flash_wr = 1'b1;
                next_flash_addr = target_base(first_slot) + {2'b00, count};
                next_flash_data = i_wdata;
                next_count = count + 16'h0001;
                if (count + 16'h0001 == IMAGE_BYTES) begin
                    next_state = UPD_COMPLETE;
                    events[IRQ_COMPLETE_BIT] = 1'b1;
                end
            end else if (state == UPD_COMPLETE) begin
                // A byte past the full image is a host fault
                next_fault = 1'b1;
                events[IRQ_FAULT_BIT] = 1'b1;
            end
        end

        if (i_flash_fault && update_mode) begin
            next_fault = 1'b1;
            events[IRQ_FAULT_BIT] = 1'b1;
        end
    end

    // Interrupt status: a new event wins over a write-one clear in the same cycle
    always_comb begin
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (wr_hit(i_wr, i_addr, ADDR_IRQ_MASK)) begin
            next_irq_mask = i_wdata[IRQ_W-1:0];
        end
        if (wr_hit(i_wr, i_addr, ADDR_IRQ_STATUS)) begin
            next_irq_status = irq_status & ~i_wdata[IRQ_W-1:0];
        end
        next_irq_status = next_irq_status | events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= UPD_IDLE;
            update_mode <= 1'b0;
            count <= COUNT_RESET;
            payload <= PAYLOAD_RESET;
            fault <= 1'b0;
            lock <= 1'b0;
            first_slot <= FIRST_SLOT_RESET;
            check_ok <= 1'b0;
            flash_wr <= 1'b0;
            flash_addr <= SLOT_FIRST_BASE;
            flash_data <= PAYLOAD_RESET;
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            irq <= 1'b0;
        end else if (i_clk_en) begin
            state <= next_state;
            update_mode <= next_update_mode;
            count <= next_count;
            payload <= next_payload;
            fault <= next_fault;
            lock <= next_lock;
            first_slot <= next_first_slot;
            check_ok <= next_check_ok;
            flash_wr <= next_flash_wr;
            flash_addr <= next_flash_addr;
            flash_data <= next_flash_data;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
        end
    end

    assign o_rdata = store_bus.rd_data;
    assign o_flash_wr = flash_wr;
    assign o_flash_addr = flash_addr;
    assign o_flash_data = flash_data;
    assign o_update_mode = update_mode;
    assign o_boot_lock = lock;
    assign o_first_slot_active = first_slot;
    assign o_irq = irq;
endmodule
`default_nettype wire

/* File: test/reg_host.sv */
// Purpose: Host model that drives the byte register port
// Assumes: Strobes are launched right after a rising edge
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module reg_host (
    input wire logic i_clk,         // System clock
    output logic [7:0] o_addr,      // Register address
    output logic [7:0] o_wdata,     // Write data
    output logic o_wr,              // Write strobe
    output logic o_rd,              // Read strobe
    input wire logic [7:0] i_rdata  // Read data
);
    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    // Back to back payload bytes, byte k carries the low byte of start + k
    task automatic burst(input logic [7:0] a, input int n, input int start);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_wr <= 1'b1;
            o_addr <= a;
            o_wdata <= 8'(start + k);
        end
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~o_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        v = i_rdata;
    endtask
endmodule
`default_nettype wire

/* File: test/color_regs_chk.sv */
// Purpose: Port-level checks of the result and image update register bank
// Assumes: One clock, asynchronous active-low reset
// Notes: Slot swap is only checked outside update mode, where it is unambiguous
`timescale 1ns/100ps
`default_nettype none
module color_regs_chk
    import color_regs_pkg::*;
(
    input wire logic i_clk,                // Clock
    input wire logic i_resetn,             // Reset, active low
    input wire logic [7:0] i_addr,         // Address
    input wire logic [7:0] i_wdata,        // Write data
    input wire logic i_wr,                 // Write strobe
    input wire logic i_rd,                 // Read strobe
    input wire logic [7:0] o_rdata,        // Read data
    input wire logic o_flash_wr,           // Flash byte request
    input wire logic [17:0] o_flash_addr,  // Flash byte address
    input wire logic [7:0] o_flash_data,   // Flash byte
    input wire logic o_update_mode,        // Update mode
    input wire logic o_boot_lock,          // Boot lock
    input wire logic o_first_slot_active   // First slot selected
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_ctrl_wr;
        i_wr && i_addr == ADDR_UPDATE_CONTROL;
    endsequence
    sequence s_pay_wr;
        i_wr && i_addr == ADDR_PAYLOAD;
    endsequence
    AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not zero outside the read slot");
    AST_START: assert property (s_ctrl_wr ##0 (i_wdata[7] && !i_wdata[6]) |=> o_update_mode)
        else $error("update mode not entered");
    AST_STOP: assert property (s_ctrl_wr ##0 i_wdata[6] |=> !o_update_mode)
        else $error("stop did not leave update mode");
    AST_LOCK: assert property (s_ctrl_wr |=> o_boot_lock == $past(i_wdata[4]))
        else $error("boot lock does not follow control write");
    AST_SWITCH: assert property (s_ctrl_wr ##0 (i_wdata[3] && !i_wdata[7] && !o_update_mode)
        |=> o_first_slot_active != $past(o_first_slot_active))
        else $error("slot did not swap");
    AST_SLOT_HOLD: assert property (!(i_wr && i_addr == ADDR_UPDATE_CONTROL && i_wdata[3])
        |=> $stable(o_first_slot_active))
        else $error("slot changed without a swap");
    AST_FLASH_CAUSE: assert property (o_flash_wr |-> $past(i_wr && i_addr == ADDR_PAYLOAD
        && o_update_mode) && o_flash_data == $past(i_wdata))
        else $error("flash write without a payload byte in update mode");
    AST_FLASH_SLOT: assert property (o_flash_wr |-> (o_flash_addr - (o_first_slot_active ?
        SLOT_SECOND_BASE : SLOT_FIRST_BASE)) < {2'b00, IMAGE_BYTES})
        else $error("flash address outside the target slot");
    AST_IDLE_PAY: assert property (s_pay_wr ##0 !o_update_mode |=> !o_flash_wr)
        else $error("payload outside update mode reached flash");
endmodule
bind color_result_and_image_update_regs color_regs_chk color_regs_chk_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_flash_wr(o_flash_wr), .o_flash_addr(o_flash_addr),
    .o_flash_data(o_flash_data), .o_update_mode(o_update_mode), .o_boot_lock(o_boot_lock),
    .o_first_slot_active(o_first_slot_active));
`default_nettype wire

/* File: test/test_color_result_and_image_update_regs.sv */
// Purpose: Register-level test of results, image stream and interrupt
// Assumes: Host model drives the bus, bench drives the result and flash side inputs
// Notes: Streams one full image, so the run is about sixty thousand cycles
`timescale 1ns/100ps
`default_nettype none
module test_color_result_and_image_update_regs;
    import color_regs_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] addr, wdata, rdata, flash_data;
    logic wr, rd, flash_wr, upd, lock, first, irq;
    logic load = 1'b0;
    logic check_ok = 1'b0;
    logic flash_fault = 1'b0;
    logic [31:0] u_p = 32'h0, v_p = 32'h0, u = 32'h0, v = 32'h0, locus = 32'h0;
    logic [15:0] lux = 16'h0, cct = 16'h0;
    logic [17:0] flash_addr;
    logic [17:0] fbase = 18'h0;
    logic [191:0] vec;
    int fcnt = 0, n_fail = 0, checks = 0, cycles = 0;
    initial forever #50 i_clk = ~i_clk;
    reg_host reg_host_inst (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
        .o_rd(rd), .i_rdata(rdata));
    color_result_and_image_update_regs color_result_and_image_update_regs_inst (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_clk_en(1'b1), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_result_load(load), .i_u_prime(u_p),
        .i_v_prime(v_p), .i_u(u), .i_v(v), .i_locus_dist(locus), .i_lux(lux), .i_cct(cct),
        .i_flash_fault(flash_fault), .i_other_check_ok(check_ok), .o_flash_wr(flash_wr),
        .o_flash_addr(flash_addr), .o_flash_data(flash_data), .o_update_mode(upd),
        .o_boot_lock(lock), .o_first_slot_active(first), .o_irq(irq));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] got;
        reg_host_inst.rd(a, got);
        check(what, {24'h0, got}, {24'h0, exp});
    endtask
    task automatic irq_chk(input logic exp);
        @(posedge i_clk);
        #1;
        check("irq", {31'h0, irq}, {31'h0, exp});
    endtask
    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Every flash request must land at the next byte of the target slot
    always @(posedge i_clk) begin
        #1;
        if (flash_wr === 1'b1) begin
            check("flash_addr", {14'h0, flash_addr}, {14'h0, fbase + 18'(fcnt)});
            check("flash_data", {24'h0, flash_data}, {24'h0, 8'(fcnt)});
            fcnt++;
        end
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 70000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd_chk(ADDR_UPDATE_CONTROL, 8'h04, "ctrl");
        rd_chk(ADDR_COUNT_UPPER, 8'h00, "count_h");
        rd_chk(ADDR_COUNT_LOWER, 8'h00, "count_l");
        rd_chk(ADDR_PAYLOAD, 8'h00, "payload");
        $display("reset test done");
        reg_host_inst.wr(ADDR_IRQ_MASK, 8'h04);
        @(posedge i_clk);
        {u_p, v_p, u, v} <= {32'h3e8a3d71, 32'h3ef0a3d7, 32'h3e570a3d, 32'h3ea3d70a};
        {locus, lux, cct} <= {32'hbba3d70a, 16'h03e8, 16'h0bb8};
        load <= 1'b1;
        @(posedge i_clk);
        load <= 1'b0;
        irq_chk(1'b1);
        vec = {u_p, v_p, u, v, locus, lux, cct};
        for (int i = 0; i < RESULT_BYTES; i++) begin
            rd_chk(ADDR_RESULT_FIRST + 8'(i), vec[191-8*i -: 8], "result");
        end
        reg_host_inst.wr(ADDR_LUX_UPPER, 8'hff);
        rd_chk(ADDR_LUX_UPPER, 8'h03, "lux_h_ro");
        rd_chk(8'h60, 8'h00, "unmapped");
        rd_chk(ADDR_IRQ_STATUS, 8'h04, "irq_status");
        reg_host_inst.wr(ADDR_IRQ_STATUS, 8'h04);
        irq_chk(1'b0);
        $display("result test done");
        reg_host_inst.wr(ADDR_UPDATE_CONTROL, 8'h80);
        rd_chk(ADDR_UPDATE_CONTROL, 8'h84, "ctrl_start");
        check("upd", {31'h0, upd}, 32'h1);
        fbase = SLOT_SECOND_BASE;
        reg_host_inst.burst(ADDR_PAYLOAD, int'(IMAGE_BYTES) - 1, 0);
        rd_chk(ADDR_COUNT_UPPER, 8'hdf, "count_h");
        rd_chk(ADDR_COUNT_LOWER, 8'hff, "count_l");
        rd_chk(ADDR_UPDATE_CONTROL, 8'h84, "ctrl_partial");
        reg_host_inst.burst(ADDR_PAYLOAD, 1, int'(IMAGE_BYTES) - 1);
        rd_chk(ADDR_UPDATE_CONTROL, 8'ha4, "ctrl_complete");
        check("flash_count", fcnt, int'(IMAGE_BYTES));
        reg_host_inst.wr(ADDR_IRQ_MASK, 8'h01);
        irq_chk(1'b1);
        reg_host_inst.wr(ADDR_IRQ_STATUS, 8'h01);
        irq_chk(1'b0);
        reg_host_inst.wr(ADDR_PAYLOAD, 8'h11);
        rd_chk(ADDR_UPDATE_CONTROL, 8'ha6, "ctrl_fault");
        check("flash_count", fcnt, int'(IMAGE_BYTES));
        $display("stream test done");
        reg_host_inst.wr(ADDR_UPDATE_CONTROL, 8'h40);
        rd_chk(ADDR_UPDATE_CONTROL, 8'h04, "ctrl_stop");
        check("upd", {31'h0, upd}, 32'h0);
        rd_chk(ADDR_COUNT_LOWER, 8'h00, "count_l");
        reg_host_inst.wr(ADDR_PAYLOAD, 8'h5a);
        rd_chk(ADDR_PAYLOAD, 8'h5a, "payload");
        rd_chk(ADDR_COUNT_LOWER, 8'h00, "count_l");
        check("flash_count", fcnt, int'(IMAGE_BYTES));
        $display("stop test done");
        reg_host_inst.wr(ADDR_UPDATE_CONTROL, 8'h18);
        rd_chk(ADDR_UPDATE_CONTROL, 8'h10, "ctrl_swap");
        check("lock", {31'h0, lock}, 32'h1);
        check("first", {31'h0, first}, 32'h0);
        @(posedge i_clk);
        check_ok <= 1'b1;
        rd_chk(ADDR_UPDATE_CONTROL, 8'h11, "ctrl_check");
        $display("slot test done");
        reg_host_inst.wr(ADDR_UPDATE_CONTROL, 8'h90);
        fbase = SLOT_FIRST_BASE;
        fcnt = 0;
        reg_host_inst.burst(ADDR_PAYLOAD, 2, 0);
        rd_chk(ADDR_COUNT_LOWER, 8'h02, "count_l");
        check("flash_count", fcnt, 2);
        // A flash write failure while receiving must raise the fault bit
        @(posedge i_clk);
        flash_fault <= 1'b1;
        @(posedge i_clk);
        flash_fault <= 1'b0;
        rd_chk(ADDR_UPDATE_CONTROL, 8'h93, "ctrl_flash_fault");
        $display("second slot test done");
        close_out();
    end
endmodule
`default_nettype wire
